/* sim/mcr_top_tb.sv */
// self-checking bench for the misc control register bank
`timescale 1ns/10ps
module mcr_top_tb;
  import mcr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic vector_fetch = 1'b0;
  logic compute_ack_in = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, flash_cache_clear, master_policy_rr, compute_request;
  mcr_flash_ctl_t flash_ctl;
  int num_errors = 0;
  int checks = 0;
  logic [31:0] rd, v;
  logic er;
  wire [31:0] outs = {25'h0, flash_cache_clear, master_policy_rr, flash_ctl};

  always #4 pclk = ~pclk;

  mcr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vector_fetch(vector_fetch), .compute_ack_in(compute_ack_in),
    .flash_ctl(flash_ctl), .flash_cache_clear(flash_cache_clear),
    .master_policy_rr(master_policy_rr), .compute_request(compute_request));

  // flash settings implied by a platform_control value
  function automatic mcr_flash_ctl_t exp_flash(input logic [31:0] p);
    return {p[16], !p[15], !p[15] & p[14], !(p[13] | p[12]), !(p[13] | p[11])};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; waits on pready, returns one step after the commit edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h4a9e));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(outs, {25'h0, 2'b00, exp_flash(MCR_ZERO)}, "reset outputs");
    apb(1'b1, MCR_ADDR_PRESENCE, $urandom, rd, er);
    chk({31'h0, er}, MCR_ZERO, "presence write error");
    apb(1'b0, MCR_ADDR_PRESENCE, MCR_ZERO, rd, er);
    chk(rd, {24'h0, MCR_MASTER_MAP}, "presence read");
    // corners first: all ones, then a lone cache clear
    for (int i = 0; i < 20; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0400 : $urandom;
      apb(1'b1, MCR_ADDR_PLATFORM, v, rd, er);
      chk(outs, {25'h0, v[10], v[9], exp_flash(v)}, "platform outputs");
      apb(1'b0, MCR_ADDR_PLATFORM, MCR_ZERO, rd, er);
      chk(rd, v & MCR_PLATFORM_WMASK & 32'hFFFF_FBFF, "platform read");
    end
    apb(1'b1, 12'h004, 32'hFFFF_FFFF, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped write error");
    apb(1'b0, 12'h004, MCR_ZERO, rd, er);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b0, MCR_ADDR_PLATFORM, MCR_ZERO, rd, er);
    chk(rd, v & MCR_PLATFORM_WMASK & 32'hFFFF_FBFF, "platform kept");
    for (int i = 0; i < 8; i++) begin
      compute_ack_in <= i[1];
      apb(1'b1, MCR_ADDR_COMPUTE, ($urandom & 32'hFFFF_FFF8) | {29'h0, i[2:0]}, rd, er);
      chk({31'h0, compute_request}, {31'h0, i[0]}, "request level");
      apb(1'b0, MCR_ADDR_COMPUTE, MCR_ZERO, rd, er);
      chk(rd, {29'h0, i[2:0]}, "compute read");
      if (i[0]) begin
        @(posedge pclk);
        vector_fetch <= 1'b1;
        @(posedge pclk);
        vector_fetch <= 1'b0;
        #1;
        chk({31'h0, compute_request}, {31'h0, !i[2]}, "vector fetch clear");
      end
    end
    end_sim;
  end

  // whole run is a few hundred cycles, far below the 25000-cycle limit
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
endmodule // mcr_top_tb

/* verilog/mcr_pkg.sv */
// package for the misc control module register bank
package mcr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] MCR_IDX_PRESENCE = 8'h0A;
  localparam logic [7:0] MCR_IDX_PLATFORM = 8'h0C;
  localparam logic [7:0] MCR_IDX_COMPUTE = 8'h40;
  localparam logic [11:0] MCR_ADDR_PRESENCE = {2'h0, MCR_IDX_PRESENCE, 2'h0};
  localparam logic [11:0] MCR_ADDR_PLATFORM = {2'h0, MCR_IDX_PLATFORM, 2'h0};
  localparam logic [11:0] MCR_ADDR_COMPUTE = {2'h0, MCR_IDX_COMPUTE, 2'h0};

  // platform_control field positions
  localparam int MCR_BIT_STALL_EN = 16;
  localparam int MCR_BIT_SPEC_DIS = 15;
  localparam int MCR_BIT_DSPEC_EN = 14;
  localparam int MCR_BIT_CACHE_DIS = 13;
  localparam int MCR_BIT_ICACHE_DIS = 12;
  localparam int MCR_BIT_DCACHE_DIS = 11;
  localparam int MCR_BIT_CACHE_CLR = 10;
  localparam int MCR_BIT_POLICY = 9;
  localparam logic [31:0] MCR_PLATFORM_WMASK = 32'h0001_FA00;
  localparam logic [31:0] MCR_PLATFORM_RST = 32'h0000_0000;

  // compute_operation_control field positions
  localparam int MCR_BIT_WAKE_INT = 2;
  localparam int MCR_BIT_ACK = 1;
  localparam int MCR_BIT_REQ = 0;

  // masters attached to crossbar input ports
  localparam logic [7:0] MCR_MASTER_MAP = 8'h0D;
  localparam logic [31:0] MCR_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic stall_en;
    logic spec_instr_en;
    logic spec_data_en;
    logic cache_instr_en;
    logic cache_data_en;
  } mcr_flash_ctl_t;

  // instruction speculation only, full caching
  localparam mcr_flash_ctl_t MCR_FLASH_RST = 5'h0B;

endpackage

/* verilog/mcr_top.sv */
// register bank for crossbar, flash controller and compute operation control
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module mcr_top
  import mcr_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic vector_fetch, // interrupt or exception vector fetch
  input wire logic compute_ack_in, // handshake state from platform
  output mcr_flash_ctl_t flash_ctl, // flash controller settings
  output logic flash_cache_clear, // one-cycle cache invalidate
  output logic master_policy_rr, // crossbar round-robin when high
  output logic compute_request // compute operation request
);

  logic [31:0] platform_control;
  logic [31:0] next_platform;
  logic compute_wake_on_interrupt;
  logic compute_acknowledge;
  logic access;
  logic done;
  logic wr_platform;
  logic wr_compute;
  logic hit;
  logic [31:0] rd_mux;
  logic auto_clear;
  logic next_request;

  assign access = psel & penable;
  assign done = access & pready;
  assign wr_platform = done & pwrite & (paddr == MCR_ADDR_PLATFORM);
  assign wr_compute = done & pwrite & (paddr == MCR_ADDR_COMPUTE);
  assign auto_clear = compute_wake_on_interrupt & vector_fetch;

  function automatic mcr_flash_ctl_t decode(input logic [31:0] r);
    mcr_flash_ctl_t c;
    c.stall_en = r[MCR_BIT_STALL_EN];
    c.spec_instr_en = ~r[MCR_BIT_SPEC_DIS];
    c.spec_data_en = ~r[MCR_BIT_SPEC_DIS] & r[MCR_BIT_DSPEC_EN];
    c.cache_instr_en = ~r[MCR_BIT_CACHE_DIS] & ~r[MCR_BIT_ICACHE_DIS];
    c.cache_data_en = ~r[MCR_BIT_CACHE_DIS] & ~r[MCR_BIT_DCACHE_DIS];
    return c;
  endfunction

  // clear bit is never stored, so it reads back zero
  always_comb begin
    next_platform = platform_control;
    if (wr_platform) begin
      next_platform = pwdata & MCR_PLATFORM_WMASK;
    end
  end

  // a write in the same cycle as a vector fetch wins: software sees its value
  always_comb begin
    next_request = compute_request;
    if (auto_clear) begin
      next_request = 1'b0;
    end
    if (wr_compute) begin
      next_request = pwdata[MCR_BIT_REQ];
    end
  end

  always_comb begin
    hit = 1'b1;
    case (paddr)
      MCR_ADDR_PRESENCE: begin
        rd_mux = {MCR_ZERO[31:8], MCR_MASTER_MAP};
      end
      MCR_ADDR_PLATFORM: begin
        rd_mux = platform_control;
      end
      MCR_ADDR_COMPUTE: begin
        rd_mux = {MCR_ZERO[31:3], compute_wake_on_interrupt, compute_acknowledge,
                  compute_request};
      end
      default: begin
        rd_mux = MCR_ZERO;
        hit = 1'b0;
      end
    endcase
  end

  // one wait state so that read data and error come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= MCR_ZERO;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~hit;
      if (access & ~pready) begin
        prdata <= pwrite ? MCR_ZERO : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      platform_control <= MCR_PLATFORM_RST;
      flash_ctl <= MCR_FLASH_RST;
      master_policy_rr <= 1'b0;
    end else begin
      platform_control <= next_platform;
      flash_ctl <= decode(next_platform);
      master_policy_rr <= next_platform[MCR_BIT_POLICY];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cache_clear <= 1'b0;
    end else begin
      flash_cache_clear <= wr_platform & pwdata[MCR_BIT_CACHE_CLR];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compute_request <= 1'b0;
      compute_wake_on_interrupt <= 1'b0;
      compute_acknowledge <= 1'b0;
    end else begin
      compute_request <= next_request;
      compute_acknowledge <= compute_ack_in;
      if (wr_compute) begin
        compute_wake_on_interrupt <= pwdata[MCR_BIT_WAKE_INT];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  presence_read_a: assert property (done && !pwrite && paddr == MCR_ADDR_PRESENCE
    |-> prdata == {MCR_ZERO[31:8], MCR_MASTER_MAP} && !pslverr)
    else $error("presence register read wrong");

  platform_resv_a: assert property (done && !pwrite && paddr == MCR_ADDR_PLATFORM
    |-> prdata[31:17] == 15'h0000 && prdata[10] == 1'b0 && prdata[8:0] == 9'h000)
    else $error("platform reserved or clear bit read nonzero");

  compute_resv_a: assert property (done && !pwrite && paddr == MCR_ADDR_COMPUTE
    |-> prdata[31:3] == 29'h0000_0000)
    else $error("compute reserved bits read nonzero");

  spec_decode_a: assert property (platform_control[MCR_BIT_SPEC_DIS]
    ? (!flash_ctl.spec_instr_en && !flash_ctl.spec_data_en)
    : (flash_ctl.spec_instr_en
       && flash_ctl.spec_data_en == platform_control[MCR_BIT_DSPEC_EN]))
    else $error("speculation control mismatch");

  cache_decode_a: assert property (
    flash_ctl.cache_instr_en == !(platform_control[MCR_BIT_CACHE_DIS]
                                  || platform_control[MCR_BIT_ICACHE_DIS])
    && flash_ctl.cache_data_en == !(platform_control[MCR_BIT_CACHE_DIS]
                                    || platform_control[MCR_BIT_DCACHE_DIS]))
    else $error("cache control mismatch");

  reset_flash_a: assert property ($past(presetn) == 1'b0
    |-> flash_ctl == MCR_FLASH_RST || $past(wr_platform))
    else $error("flash settings wrong after reset");

  stall_policy_a: assert property (flash_ctl.stall_en == platform_control[MCR_BIT_STALL_EN]
    && master_policy_rr == platform_control[MCR_BIT_POLICY])
    else $error("stall or policy output mismatch");

  cache_clear_a: assert property (
    wr_platform && pwdata[MCR_BIT_CACHE_CLR] |=> flash_cache_clear ##1 !flash_cache_clear)
    else $error("cache clear pulse wrong");

  no_clear_a: assert property (!(wr_platform && pwdata[MCR_BIT_CACHE_CLR])
    |=> !flash_cache_clear)
    else $error("spurious cache clear");

  auto_clear_a: assert property (compute_wake_on_interrupt && vector_fetch && !wr_compute
    |=> !compute_request)
    else $error("request not cleared on vector fetch");

  request_hold_a: assert property (!wr_compute && !(compute_wake_on_interrupt && vector_fetch)
    |=> $stable(compute_request))
    else $error("request changed without cause");

  ack_read_a: assert property (done && !pwrite && paddr == MCR_ADDR_COMPUTE
    |-> prdata[MCR_BIT_ACK] == $past(compute_ack_in, 2))
    else $error("acknowledge read wrong");

  apb_answer_a: assert property (access && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // apb answer, error and read data
  pslverr_ready_a: assert property (pslverr
    |-> pready)
    else $error("error shown without ready");

  unmapped_err_a: assert property (access && !pready && !hit
    |=> pslverr)
    else $error("unmapped access not flagged");

  mapped_ok_a: assert property (access && !pready && hit
    |=> !pslverr)
    else $error("mapped access flagged as error");

  write_rdata_a: assert property (done && pwrite
    |-> prdata == MCR_ZERO)
    else $error("read data nonzero on write");

  pready_idle_a: assert property (!access
    |=> !pready)
    else $error("ready without access");

  rdata_hold_a: assert property (!(access && !pready)
    |=> $stable(prdata))
    else $error("read data changed outside access");

  // register storage
  platform_wr_a: assert property (wr_platform
    |=> platform_control == ($past(pwdata) & MCR_PLATFORM_WMASK))
    else $error("platform write stored wrong");

  platform_hold_a: assert property (!wr_platform
    |=> $stable(platform_control))
    else $error("platform register changed without write");

  clear_unstored_a: assert property (
    platform_control[MCR_BIT_CACHE_CLR] == 1'b0)
    else $error("cache clear bit stored");

  resv_unstored_a: assert property (
    (platform_control & ~MCR_PLATFORM_WMASK) == MCR_ZERO)
    else $error("reserved platform bits stored");

  presence_ro_a: assert property (done && pwrite && paddr == MCR_ADDR_PRESENCE
    |=> $stable(platform_control) && $stable(compute_wake_on_interrupt))
    else $error("presence write disturbed other registers");

  // flash and crossbar outputs
  stall_wr_a: assert property (wr_platform && pwdata[MCR_BIT_STALL_EN]
    |=> flash_ctl.stall_en)
    else $error("stall not enabled by write");

  stall_off_a: assert property (wr_platform && !pwdata[MCR_BIT_STALL_EN]
    |=> !flash_ctl.stall_en)
    else $error("stall not disabled by write");

  policy_rr_a: assert property (wr_platform && pwdata[MCR_BIT_POLICY]
    |=> master_policy_rr)
    else $error("round-robin not selected");

  policy_fixed_a: assert property (wr_platform && !pwdata[MCR_BIT_POLICY]
    |=> !master_policy_rr)
    else $error("fixed priority not selected");

  spec_off_a: assert property (wr_platform && pwdata[MCR_BIT_SPEC_DIS]
    |=> !flash_ctl.spec_instr_en && !flash_ctl.spec_data_en)
    else $error("speculation not fully off");

  cache_off_a: assert property (wr_platform && pwdata[MCR_BIT_CACHE_DIS]
    |=> !flash_ctl.cache_instr_en && !flash_ctl.cache_data_en)
    else $error("cache not fully off");

  // compute operation control
  wake_set_a: assert property (wr_compute && pwdata[MCR_BIT_WAKE_INT]
    |=> compute_wake_on_interrupt)
    else $error("wake bit not set by write");

  wake_clr_a: assert property (wr_compute && !pwdata[MCR_BIT_WAKE_INT]
    |=> !compute_wake_on_interrupt)
    else $error("wake bit not cleared by write");

  wake_hold_a: assert property (!wr_compute
    |=> $stable(compute_wake_on_interrupt))
    else $error("wake bit changed without write");

  request_set_a: assert property (wr_compute && pwdata[MCR_BIT_REQ]
    |=> compute_request)
    else $error("request not set by write");

  request_clr_a: assert property (wr_compute && !pwdata[MCR_BIT_REQ]
    |=> !compute_request)
    else $error("request not cleared by write");

  ack_follow_a: assert property (1'b1
    |=> compute_acknowledge == $past(compute_ack_in))
    else $error("acknowledge does not follow handshake");

endmodule // mcr_top
